// File: rtl/pvcr_cfg.svh
/*
  Offsets, field positions, reset values and load fractions of the vendor
  configuration command bank.
  Assumes it is included by bare name from the design modules and the bench.
*/
`ifndef PVCR_CFG_SVH
`define PVCR_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define PVCR_CMD_MODE        8'hDD
`define PVCR_CMD_RAMP        8'hDE
`define PVCR_CMD_SHED        8'hDF
`define PVCR_CMD_LOCKOUT     8'hE0
`define PVCR_CMD_PHASE       8'hE4
`define PVCR_CMD_UVOFS       8'hE6
`define PVCR_CMD_IDENT       8'hFC
`define PVCR_CMD_STATUS      8'h80

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PVCR_MODE_PROTO_BIT  7
`define PVCR_MODE_PAIR_BIT   6
`define PVCR_MODE_SPARE_BIT  5
`define PVCR_MODE_SHED_BIT   4
`define PVCR_MODE_FLAT_BIT   3
`define PVCR_SHED_LOW_BIT    3
`define PVCR_STAT_PHASE_BIT  3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PVCR_RST_MODE        8'h89
`define PVCR_RST_RAMP        3'h6
`define PVCR_RST_SHED        4'h1
`define PVCR_RST_LOCKOUT     2'h1
`define PVCR_RST_UVOFS       3'h3

// ----------------------------------------------------------------------------
// Load fractions in percent and the full-load multiplier
// ----------------------------------------------------------------------------
`define PVCR_FULL_LOAD_MULT  3'h4
`define PVCR_PCT_SINGLE      7'h0A
`define PVCR_PCT_DUAL_BASE   7'h0F
`define PVCR_PCT_DUAL_STEP   7'h05
`define PVCR_PCT_DUAL_MAX    7'h23
`define PVCR_PCT_SCALE       7'h64

`endif

// File: rtl/pvcr_pkg.sv
/*
  Types shared by the vendor configuration command bank.
  Assumes nothing of its surroundings.
*/
package pvcr_pkg;

  typedef enum logic [1:0] {
    PVCR_BOOT = 2'b00,
    PVCR_RUN  = 2'b01
  } pvcr_state_e;

  typedef logic [2:0] pvcr_code_t;

endpackage

// File: rtl/pvcr_uv_calc.sv
/*
  Output undervoltage fault threshold calculator.
  Assumes the load line is given in 1/16 milliohm and the current in amperes,
  all inputs synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pvcr_cfg.svh"

module pvcr_uv_calc (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Operands
  input  wire logic [15:0] vout_cmd_mv,
  input  wire logic [7:0]  loadline_q4,
  input  wire logic [7:0]  iout_a,
  input  wire logic        flat_loadline_sel,
  input  wire logic [8:0]  offset_mv,
  // Result
  output logic      [15:0] uv_threshold_mv
);
  import pvcr_pkg::*;

  logic [15:0] drop_prod;
  logic [17:0] diff;
  logic [15:0] next_uv_threshold_mv;

  // A flat load line removes the current-dependent term entirely.
  always_comb begin
    drop_prod = flat_loadline_sel ? 16'h0000 : loadline_q4 * iout_a;
    diff = {2'b00, vout_cmd_mv} - {6'h00, drop_prod[15:4]} - {9'h000, offset_mv};
    // Clamp at zero so a large drop cannot wrap to a huge threshold.
    next_uv_threshold_mv = diff[17] ? 16'h0000 : diff[15:0];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uv_threshold_mv <= 16'h0000;
    end else begin
      uv_threshold_mv <= next_uv_threshold_mv;
    end
  end

  property p_uv_flat;
    @(posedge clk) disable iff (!rstn)
    (flat_loadline_sel && vout_cmd_mv >= 16'h0200)
      |=> uv_threshold_mv == $past(vout_cmd_mv) - {7'h00, $past(offset_mv)};
  endproperty
  a_uv_flat: assert property (p_uv_flat) else $error("flat load line threshold wrong");

  property p_uv_drop;
    @(posedge clk) disable iff (!rstn)
    (!flat_loadline_sel && iout_a == 8'h14 && loadline_q4 == 8'h10 && vout_cmd_mv == 16'h03E8)
      |=> uv_threshold_mv == 16'h03E8 - 16'h0014 - {7'h00, $past(offset_mv)};
  endproperty
  a_uv_drop: assert property (p_uv_drop) else $error("load line drop not subtracted");

endmodule
`default_nettype wire

// File: rtl/pvcr_regs.sv
/*
  Vendor configuration and identification command bank of a multi-phase buck
  controller, with phase-shedding decision and derived analog settings.
  Assumes a command-layer front end that presents one decoded read or write
  per cycle, and straps and telemetry that are synchronous to clk.
*/
// What this block does
// - Mode bit 7 picks newer regulator protocol at 0, older at 1.
// - Interleave bit picks four single phases at 0, paired 1/3 and 2/4 at 1.
// - Mode bit 5 is stored but steers nothing.
// - Shed enable bit turns dynamic phase shedding off at 0, on at 1.
// - Load-line bit picks non-zero load line at 0, zero load line at 1.
// - Slew code selects eight rates from 0.34 to 2.74 mV/us.
// - Ramp code gives 20 to 120 mV in 20 mV steps, 200 mV at 111.
// - A host write to the ramp register overrides the strap default.
// - Shed fractions are taken against four times the per-phase current limit.
// - Low shed bit blocks single phase at 0; at 1 sheds below 10 percent.
// - High shed code sets 15, 20, 25, 30, else 35 percent for dual phase.
// - Lockout code picks 4.5, 7.25, 9.0, 10.3 V; resets to 01.
// - Phase limit is code plus one and applies while running.
// - Too many phases requested: keep count, set status bit 3, raise alert.
// - Offset code picks 50 to 400 mV per the fixed table.
// - Fault threshold is commanded voltage minus load-line drop minus offset.
// - A read-only 16-bit identification code is readable.
`timescale 1ns/1ps
`default_nettype none
`include "pvcr_cfg.svh"

module pvcr_regs #(
  // Arbitrary neutral value, not that of any real part.
  parameter logic [15:0] IDENT_CODE = 16'h5A3C
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Command port
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_rvalid,
  output logic             cmd_unmapped,
  // Straps and hardware limits
  input  wire logic [7:0]  mode_strap,
  input  wire logic [2:0]  current_limit_ramp_strap,
  input  wire logic [2:0]  hw_phase_avail,
  // Telemetry
  input  wire logic [7:0]  iout_a,
  input  wire logic [7:0]  ocl_per_phase_a,
  input  wire logic [15:0] vout_cmd_mv,
  input  wire logic [7:0]  loadline_q4,
  // Controls to the power stage
  output logic             regulator_protocol_sel,
  output logic             interleave_pairing,
  output logic             shed_enable,
  output logic             flat_loadline_sel,
  output logic      [11:0] slew_rate_uv_per_us,
  output logic      [7:0]  ramp_amplitude_mv,
  output logic      [13:0] input_lockout_mv,
  output logic      [2:0]  active_phase_count,
  output logic      [15:0] uv_threshold_mv,
  output logic             host_alert_out
);
  import pvcr_pkg::*;

  // --------------------------------------------------------------------------
  // Level tables
  // --------------------------------------------------------------------------
  function automatic logic [11:0] slew_lut(input pvcr_code_t c);
    unique case (c)
      3'h0:    slew_lut = 12'h154;
      3'h1:    slew_lut = 12'h2A8;
      3'h2:    slew_lut = 12'h3FC;
      3'h3:    slew_lut = 12'h550;
      3'h4:    slew_lut = 12'h6A4;
      3'h5:    slew_lut = 12'h7F8;
      3'h6:    slew_lut = 12'h94C;
      default: slew_lut = 12'hAB4;
    endcase
  endfunction

  // Code 110 has no printed level; it is held at the 120 mV step.
  function automatic logic [7:0] ramp_lut(input pvcr_code_t c);
    if (c == 3'h7) begin
      ramp_lut = 8'hC8;
    end else if (c == 3'h6) begin
      ramp_lut = 8'h78;
    end else begin
      ramp_lut = {c, 2'b00} * 8'h05 + 8'h14;
    end
  endfunction

  function automatic logic [13:0] lockout_lut(input logic [1:0] c);
    unique case (c)
      2'h0:    lockout_lut = 14'h1194;
      2'h1:    lockout_lut = 14'h1C52;
      2'h2:    lockout_lut = 14'h2328;
      default: lockout_lut = 14'h283C;
    endcase
  endfunction

  function automatic logic [8:0] offset_lut(input pvcr_code_t c);
    unique case (c)
      3'h6:    offset_lut = 9'h145;
      3'h7:    offset_lut = 9'h190;
      default: offset_lut = ({6'h00, c} + 9'h001) * 9'h032;
    endcase
  endfunction

  // True when the load lies below pct percent of the full-load reference.
  function automatic logic below_pct(input logic [7:0] i, input logic [10:0] full,
                                     input logic [6:0] pct);
    below_pct = ({3'h0, i} * `PVCR_PCT_SCALE) < ({7'h00, full} * {11'h000, pct});
  endfunction

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  pvcr_state_e state, next_state;
  logic [7:0]  mode_reg, next_mode_reg;
  pvcr_code_t  ramp_code, next_ramp_code;
  logic [3:0]  shed_reg, next_shed_reg;
  logic [1:0]  lockout_code, next_lockout_code;
  pvcr_code_t  phase_code, next_phase_code;
  pvcr_code_t  uvofs_code, next_uvofs_code;
  logic        phase_fault, next_phase_fault;
  logic [3:0]  phase_req;
  logic        phase_reject;

  assign phase_req    = {1'b0, cmd_wdata[2:0]} + 4'h1;
  assign phase_reject = cmd_wr && cmd_code == `PVCR_CMD_PHASE
                        && phase_req > {1'b0, hw_phase_avail};

  always_comb begin
    next_state        = PVCR_RUN;
    next_mode_reg     = mode_reg;
    next_ramp_code    = ramp_code;
    next_shed_reg     = shed_reg;
    next_lockout_code = lockout_code;
    next_phase_code   = phase_code;
    next_uvofs_code   = uvofs_code;
    next_phase_fault  = phase_fault;
    // Straps are caught in the first cycle after reset; a write in the same
    // cycle is applied after them so the host setting still wins.
    if (state == PVCR_BOOT) begin
      next_mode_reg   = mode_strap;
      next_ramp_code  = current_limit_ramp_strap;
      next_phase_code = hw_phase_avail - 3'h1;
    end
    if (cmd_wr) begin
      unique case (cmd_code)
        `PVCR_CMD_MODE:    next_mode_reg = cmd_wdata[7:0];
        `PVCR_CMD_RAMP:    next_ramp_code = cmd_wdata[2:0];
        `PVCR_CMD_SHED:    next_shed_reg = cmd_wdata[3:0];
        `PVCR_CMD_LOCKOUT: next_lockout_code = cmd_wdata[1:0];
        `PVCR_CMD_PHASE: begin
          if (!phase_reject) begin
            next_phase_code = cmd_wdata[2:0];
          end
        end
        `PVCR_CMD_UVOFS:   next_uvofs_code = cmd_wdata[2:0];
        `PVCR_CMD_STATUS: begin
          if (cmd_wdata[`PVCR_STAT_PHASE_BIT]) begin
            next_phase_fault = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // The rejection sets after any clear so a simultaneous event survives.
    if (phase_reject) begin
      next_phase_fault = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state        <= PVCR_BOOT;
      mode_reg     <= `PVCR_RST_MODE;
      ramp_code    <= `PVCR_RST_RAMP;
      shed_reg     <= `PVCR_RST_SHED;
      lockout_code <= `PVCR_RST_LOCKOUT;
      phase_code   <= 3'h0;
      uvofs_code   <= `PVCR_RST_UVOFS;
      phase_fault  <= 1'b0;
    end else begin
      state        <= next_state;
      mode_reg     <= next_mode_reg;
      ramp_code    <= next_ramp_code;
      shed_reg     <= next_shed_reg;
      lockout_code <= next_lockout_code;
      phase_code   <= next_phase_code;
      uvofs_code   <= next_uvofs_code;
      phase_fault  <= next_phase_fault;
    end
  end

  // --------------------------------------------------------------------------
  // Derived controls and phase shedding
  // --------------------------------------------------------------------------
  logic [10:0] full_load;
  logic [6:0]  dual_pct;
  logic [2:0]  phase_limit;
  logic [2:0]  next_active_phase_count;

  always_comb begin
    full_load   = {3'h0, ocl_per_phase_a} * {8'h00, `PVCR_FULL_LOAD_MULT};
    dual_pct    = shed_reg[2:0] > 3'h3 ? `PVCR_PCT_DUAL_MAX
                  : `PVCR_PCT_DUAL_BASE + {4'h0, shed_reg[2:0]} * `PVCR_PCT_DUAL_STEP;
    phase_limit = phase_code + 3'h1;
    next_active_phase_count = phase_limit;
    if (mode_reg[`PVCR_MODE_SHED_BIT]) begin
      if (shed_reg[`PVCR_SHED_LOW_BIT] && below_pct(iout_a, full_load, `PVCR_PCT_SINGLE)) begin
        next_active_phase_count = 3'h1;
      end else if (below_pct(iout_a, full_load, dual_pct) && phase_limit > 3'h2) begin
        next_active_phase_count = 3'h2;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regulator_protocol_sel <= 1'b0;
      interleave_pairing     <= 1'b0;
      shed_enable            <= 1'b0;
      flat_loadline_sel      <= 1'b0;
      slew_rate_uv_per_us    <= 12'h000;
      ramp_amplitude_mv      <= 8'h00;
      input_lockout_mv       <= 14'h0000;
      active_phase_count     <= 3'h1;
      host_alert_out         <= 1'b0;
    end else begin
      regulator_protocol_sel <= mode_reg[`PVCR_MODE_PROTO_BIT];
      interleave_pairing     <= mode_reg[`PVCR_MODE_PAIR_BIT];
      shed_enable            <= mode_reg[`PVCR_MODE_SHED_BIT];
      flat_loadline_sel      <= mode_reg[`PVCR_MODE_FLAT_BIT];
      slew_rate_uv_per_us    <= slew_lut(mode_reg[2:0]);
      ramp_amplitude_mv      <= ramp_lut(ramp_code);
      input_lockout_mv       <= lockout_lut(lockout_code);
      active_phase_count     <= next_active_phase_count;
      host_alert_out         <= next_phase_fault;
    end
  end

  pvcr_uv_calc u_uv_calc (
    .clk               (clk),
    .rstn              (rstn),
    .vout_cmd_mv       (vout_cmd_mv),
    .loadline_q4       (loadline_q4),
    .iout_a            (iout_a),
    .flat_loadline_sel (mode_reg[`PVCR_MODE_FLAT_BIT]),
    .offset_mv         (offset_lut(uvofs_code)),
    .uv_threshold_mv   (uv_threshold_mv)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [15:0] next_cmd_rdata;
  logic        next_cmd_unmapped;

  always_comb begin
    next_cmd_rdata    = 16'h0000;
    next_cmd_unmapped = 1'b0;
    if (cmd_rd) begin
      unique case (cmd_code)
        `PVCR_CMD_MODE:    next_cmd_rdata = {8'h00, mode_reg};
        `PVCR_CMD_RAMP:    next_cmd_rdata = {13'h0000, ramp_code};
        `PVCR_CMD_SHED:    next_cmd_rdata = {12'h000, shed_reg};
        `PVCR_CMD_LOCKOUT: next_cmd_rdata = {14'h0000, lockout_code};
        `PVCR_CMD_PHASE:   next_cmd_rdata = {13'h0000, phase_code};
        `PVCR_CMD_UVOFS:   next_cmd_rdata = {13'h0000, uvofs_code};
        `PVCR_CMD_IDENT:   next_cmd_rdata = IDENT_CODE;
        `PVCR_CMD_STATUS:  next_cmd_rdata = {12'h000, phase_fault, 3'h0};
        default:           next_cmd_unmapped = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_rdata    <= 16'h0000;
      cmd_rvalid   <= 1'b0;
      cmd_unmapped <= 1'b0;
    end else begin
      cmd_rdata    <= next_cmd_rdata;
      cmd_rvalid   <= cmd_rd;
      cmd_unmapped <= next_cmd_unmapped;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_proto;
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && cmd_code == `PVCR_CMD_MODE) |=> ##1 regulator_protocol_sel == $past(cmd_wdata[7], 2);
  endproperty
  a_proto: assert property (p_proto) else $error("protocol select not applied");

  property p_pair;
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && cmd_code == `PVCR_CMD_MODE) |=> ##1 interleave_pairing == $past(cmd_wdata[6], 2);
  endproperty
  a_pair: assert property (p_pair) else $error("interleave pairing not applied");

  property p_spare;
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && cmd_code == `PVCR_CMD_MODE && state == PVCR_RUN
     && cmd_wdata[7:0] == (mode_reg ^ 8'h20)) |=> ##1 $stable(slew_rate_uv_per_us)
      && $stable(shed_enable) && $stable(flat_loadline_sel) && $stable(interleave_pairing);
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit changed behaviour");

  property p_noshed;
    @(posedge clk) disable iff (!rstn)
    !mode_reg[`PVCR_MODE_SHED_BIT] |=> active_phase_count == $past(phase_code) + 3'h1;
  endproperty
  a_noshed: assert property (p_noshed) else $error("phases shed while disabled");

  property p_single;
    @(posedge clk) disable iff (!rstn)
    (!shed_reg[`PVCR_SHED_LOW_BIT] && phase_code != 3'h0) |=> active_phase_count != 3'h1;
  endproperty
  a_single: assert property (p_single) else $error("single phase reached while blocked");

  property p_slew_top;
    @(posedge clk) disable iff (!rstn)
    mode_reg[2:0] == 3'h7 |=> slew_rate_uv_per_us == 12'hAB4;
  endproperty
  a_slew_top: assert property (p_slew_top) else $error("top slew rate wrong");

  property p_ramp_wr;
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && cmd_code == `PVCR_CMD_RAMP && cmd_wdata[2:0] == 3'h7)
      |=> ##1 ramp_amplitude_mv == 8'hC8;
  endproperty
  a_ramp_wr: assert property (p_ramp_wr) else $error("ramp write lost");

  property p_reject;
    @(posedge clk) disable iff (!rstn)
    phase_reject |=> phase_fault && $stable(phase_code) && host_alert_out;
  endproperty
  a_reject: assert property (p_reject) else $error("phase overrun not flagged");

  property p_ident;
    @(posedge clk) disable iff (!rstn)
    (cmd_rd && cmd_code == `PVCR_CMD_IDENT) |=> cmd_rvalid && cmd_rdata == IDENT_CODE;
  endproperty
  a_ident: assert property (p_ident) else $error("identification code wrong");

  property p_resv;
    @(posedge clk) disable iff (!rstn)
    (cmd_rd && cmd_code == `PVCR_CMD_PHASE) |=> cmd_rdata[15:3] == 13'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

endmodule
`default_nettype wire

// File: verification/pvcr_host_model.sv
/*
  Host-side command master that reads and writes the vendor configuration bank.
  Assumes the bank takes a strobe at a rising edge and answers a read one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module pvcr_host_model (
  // Clock
  input  wire logic        clk,
  // Command port
  output logic      [7:0]  cmd_code,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic      [15:0] cmd_wdata,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_rvalid,
  input  wire logic        cmd_unmapped
);
  initial begin
    cmd_code  = 8'h00;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // --------------------------------------------------------------------------
  // Transfers
  // --------------------------------------------------------------------------
  // Idle lines carry the inverse of the last value, so a stale code or data
  // word can never pass for a live one.
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    #1;
    cmd_code  = code;
    cmd_wdata = data;
    cmd_wr    = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr    = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~data;
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic unm);
    @(posedge clk);
    #1;
    cmd_code = code;
    cmd_rd   = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd   = 1'b0;
    cmd_code = ~code;
    // The answer stands for one cycle only, so it is taken in that cycle.
    data = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hXXXX;
    unm  = cmd_unmapped;
  endtask

  // Write in one cycle and read the same command in the very next one.
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] wdat,
                       output logic [15:0] data);
    @(posedge clk);
    #1;
    cmd_code  = code;
    cmd_wdata = wdat;
    cmd_wr    = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr    = 1'b0;
    cmd_wdata = ~wdat;
    cmd_rd    = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd    = 1'b0;
    cmd_code  = ~code;
    data = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hXXXX;
  endtask
endmodule

`default_nettype wire

// File: verification/pvcr_regs_tb_top.sv
/*
  Self-checking bench for the vendor configuration bank.
  Assumes derived outputs follow two edges after a write and reads answer one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pvcr_cfg.svh"

module pvcr_regs_tb_top;
  import pvcr_pkg::*;

  // Arbitrary identification value.
  localparam logic [15:0] ID_VAL = 16'hC3A5;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [2:0]  sel;
    logic [15:0] out;
  } pvcr_row_s;

  logic        clk, rstn, cmd_wr, cmd_rd, cmd_rvalid, cmd_unmapped, host_alert_out;
  logic [7:0]  cmd_code, mode_strap, iout_a, ocl_per_phase_a, loadline_q4, ramp_amplitude_mv;
  logic [15:0] cmd_wdata, cmd_rdata, vout_cmd_mv, uv_threshold_mv;
  logic [2:0]  current_limit_ramp_strap, hw_phase_avail, active_phase_count;
  logic        regulator_protocol_sel, interleave_pairing, shed_enable, flat_loadline_sel;
  logic [11:0] slew_rate_uv_per_us;
  logic [13:0] input_lockout_mv;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  pvcr_row_s   rows[$];
  logic [15:0] slew_t[8] = '{16'h0154, 16'h02A8, 16'h03FC, 16'h0550,
                             16'h06A4, 16'h07F8, 16'h094C, 16'h0AB4};
  logic [15:0] ramp_t[8] = '{16'h0014, 16'h0028, 16'h003C, 16'h0050,
                             16'h0064, 16'h0078, 16'h0078, 16'h00C8};
  logic [15:0] lock_t[4] = '{16'h1194, 16'h1C52, 16'h2328, 16'h283C};
  logic [15:0] ofs_t[8]  = '{16'h0032, 16'h0064, 16'h0096, 16'h00C8,
                             16'h00FA, 16'h012C, 16'h0145, 16'h0190};
  logic [7:0]  rst_c[7]  = '{`PVCR_CMD_MODE, `PVCR_CMD_RAMP, `PVCR_CMD_SHED,
                             `PVCR_CMD_LOCKOUT, `PVCR_CMD_UVOFS, `PVCR_CMD_PHASE,
                             `PVCR_CMD_IDENT};
  logic [15:0] rst_v[7]  = '{16'h005A, 16'h0002, 16'h0001, 16'h0001, 16'h0003,
                             16'h0003, ID_VAL};

  // --------------------------------------------------------------------------
  // Design and host
  // --------------------------------------------------------------------------
  pvcr_regs #(.IDENT_CODE(ID_VAL)) dut_u (
    .clk, .rstn, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_rvalid,
    .cmd_unmapped, .mode_strap, .current_limit_ramp_strap, .hw_phase_avail, .iout_a,
    .ocl_per_phase_a, .vout_cmd_mv, .loadline_q4, .regulator_protocol_sel,
    .interleave_pairing, .shed_enable, .flat_loadline_sel, .slew_rate_uv_per_us,
    .ramp_amplitude_mv, .input_lockout_mv, .active_phase_count, .uv_threshold_mv,
    .host_alert_out
  );

  pvcr_host_model host_u (
    .clk, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_unmapped
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic add(input logic [7:0] c, input logic [7:0] w, input logic [7:0] r,
                     input logic [2:0] s, input logic [15:0] o);
    rows.push_back('{c, w, r, s, o});
  endtask

  // Load changes reach the phase decision one cycle later; two edges are allowed.
  task automatic load(input logic [7:0] a);
    @(posedge clk);
    #1;
    iout_a = a;
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] out_of(input logic [2:0] sel);
    case (sel)
      3'h0: out_of = {4'h0, slew_rate_uv_per_us};
      3'h1: out_of = {8'h00, ramp_amplitude_mv};
      3'h2: out_of = {2'h0, input_lockout_mv};
      3'h3: out_of = uv_threshold_mv;
      default: out_of = {12'h000, regulator_protocol_sel, interleave_pairing,
                         shed_enable, flat_loadline_sel};
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Clock, timeout and sequence
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    logic [15:0] d;
    logic        u;
    logic [7:0]  w;
    logic [7:0]  thr;
    rstn = 1'b0;
    mode_strap = 8'h5A;
    current_limit_ramp_strap = 3'h2;
    hw_phase_avail = 3'h4;
    iout_a = 8'h14;
    ocl_per_phase_a = 8'h0A;
    vout_cmd_mv = 16'h03E8;
    loadline_q4 = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    chk("reset outputs", {host_alert_out, active_phase_count, slew_rate_uv_per_us},
        16'h1000);
    rstn = 1'b1;
    foreach (rst_c[i]) begin
      host_u.rd(rst_c[i], d, u);
      chk("reset value", d, rst_v[i]);
    end
    host_u.wr(`PVCR_CMD_IDENT, 16'hFFFF);
    host_u.rd(`PVCR_CMD_IDENT, d, u);
    chk("ident after write", d, ID_VAL);
    host_u.rd(8'h81, d, u);
    chk("unmapped data", d, 16'h0000);
    chk("unmapped flag", {15'h0000, u}, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      w = 8'h80 >> i;
      add(`PVCR_CMD_MODE, w, w, 3'h4, {12'h000, w[7], w[6], w[4], w[3]});
    end
    for (int i = 0; i < 8; i++) begin
      add(`PVCR_CMD_MODE, 8'h08 | i, 8'h08 | i, 3'h0, slew_t[i]);
      add(`PVCR_CMD_RAMP, 8'hF8 | i, i, 3'h1, ramp_t[i]);
    end
    // Flips only the spare mode bit; no derived setting may move.
    add(`PVCR_CMD_MODE, 8'h2F, 8'h2F, 3'h0, slew_t[7]);
    for (int i = 0; i < 4; i++)
      add(`PVCR_CMD_LOCKOUT, 8'hFC | i, i, 3'h2, lock_t[i]);
    for (int i = 0; i < 8; i++)
      add(`PVCR_CMD_UVOFS, 8'hF8 | i, i, 3'h3, 16'h03E8 - ofs_t[i]);
    foreach (rows[i]) begin
      host_u.wr(rows[i].code, {8'h00, rows[i].wd});
      host_u.rd(rows[i].code, d, u);
      chk("readback", d, {8'h00, rows[i].rd});
      chk("derived", out_of(rows[i].sel), rows[i].out);
    end
    host_u.wr(`PVCR_CMD_MODE, 16'h0000);
    loadline_q4 = 8'h10;
    host_u.wr_rd(`PVCR_CMD_UVOFS, 16'h0005, d);
    chk("back to back", d, 16'h0005);
    chk("uv threshold", uv_threshold_mv, 16'h02A8);
    host_u.wr(`PVCR_CMD_PHASE, 16'h00F9);
    host_u.rd(`PVCR_CMD_PHASE, d, u);
    chk("phase code", d, 16'h0001);
    chk("phases running", {13'h0000, active_phase_count}, 16'h0002);
    host_u.wr(`PVCR_CMD_PHASE, 16'h0004);
    host_u.rd(`PVCR_CMD_PHASE, d, u);
    chk("phase kept", d, 16'h0001);
    chk("alert", {15'h0000, host_alert_out}, 16'h0001);
    host_u.rd(`PVCR_CMD_STATUS, d, u);
    chk("status", d, 16'h0008);
    chk("phases kept", {13'h0000, active_phase_count}, 16'h0002);
    host_u.wr(`PVCR_CMD_STATUS, 16'h0008);
    host_u.rd(`PVCR_CMD_STATUS, d, u);
    chk("alert cleared", {host_alert_out, d[14:0]}, 16'h0000);
    host_u.wr(`PVCR_CMD_PHASE, 16'h0003);
    host_u.wr(`PVCR_CMD_MODE, 16'h0010);
    host_u.wr(`PVCR_CMD_SHED, 16'h0000);
    load(8'h00);
    chk("single blocked", {13'h0000, active_phase_count}, 16'h0002);
    for (int c = 0; c < 8; c++) begin
      host_u.wr(`PVCR_CMD_SHED, {13'h0000, c[2:0]});
      thr = (c < 4) ? (8'h06 + 8'h02 * c[7:0]) : 8'h0E;
      load(thr - 8'h01);
      chk("dual below", {13'h0000, active_phase_count}, 16'h0002);
      load(thr);
      chk("dual at", {13'h0000, active_phase_count}, 16'h0004);
    end
    host_u.wr(`PVCR_CMD_SHED, 16'h0008);
    load(8'h03);
    chk("single below", {13'h0000, active_phase_count}, 16'h0001);
    load(8'h04);
    chk("single at", {13'h0000, active_phase_count}, 16'h0002);
    complete_run();
  end
endmodule

`default_nettype wire
